// *** pwrup_map.vh ***
// Purpose: constants for the power-up delay sequencer
// Assumes: APB register byte addresses, 25 MHz pclk
// Notes: offsets and bit positions are byte addresses and bit indices
`ifndef PWRUP_MAP_VH
`define PWRUP_MAP_VH

`define CLK_HZ 25000000
`define CLK_KHZ 25000
// Register byte offsets
`define OFF_CONFIG 12'h000
`define OFF_OSC_CTRL 12'h004
`define OFF_EE_CTRL 12'h008
`define OFF_UNLOCK_KEY 12'h00C
`define OFF_STATUS 12'h010
// config_word_three_high fields
`define CFG_POWER_UP_TIMER_EN_N 0
`define CFG_OSC_MODE_LO 1
`define CFG_PLL_EN 4
`define CFG_FAST_START 5
`define CFG_RESET_VAL 6'h01
// oscillator_control_reg fields
`define OSC_STABLE_BIT 0
// EEPROM control fields
`define EE_EEPROM_WRITE_ENABLE_BIT 0
`define EE_WR_BIT 1
// Status fields
`define ST_IN_RESET 0
`define ST_POWER_UP_TIMER_RUN 1
`define ST_OST_DONE 2
`define ST_PLL_DONE 3
`define ST_CSD_DONE 4
`define ST_CLK_RUN 5
// Oscillator modes
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_EC 3'h3
`define MODE_RC 3'h4
`define MODE_INTOSC 3'h5
// Unlock keys
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
// Timing
`define OST_CYCLES 1024
`define PLL_LOCK_US 2000
`define PLL_LOCK_CYC ((`PLL_LOCK_US * (`CLK_HZ / 1000000)))
`define POWER_UP_TIMER_US 65000
`define POWER_UP_TIMER_CYC ((`POWER_UP_TIMER_US * (`CLK_HZ / 1000000)))
`define CSD_US 10
`define CSD_CYC ((`CSD_US * (`CLK_HZ / 1000000)))

`endif

// *** delay_counter.v ***
// Purpose: one-shot delay counter, done after COUNT ticks once started
// Assumes: start is a level held high while the delay is wanted
// Notes: done stays high until start falls
`timescale 1ns/1ps
module delay_counter #(
	parameter WIDTH = 24,
	parameter [WIDTH-1:0] COUNT = 24'h00_0010
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire tick,
	output wire done
);
	reg [WIDTH-1:0] cnt_ff;
	reg done_ff;
	wire [WIDTH-1:0] nxt_cnt;
	wire nxt_done;

	assign nxt_done = start & (done_ff | (tick & (cnt_ff == COUNT - 1'b1)));
	assign nxt_cnt = (!start || done_ff) ? {WIDTH{1'b0}} :
		(tick ? cnt_ff + 1'b1 : cnt_ff);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= {WIDTH{1'b0}};
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done = done_ff;
endmodule // delay_counter

// *** power_up_delay_sequencer.v ***
// Purpose: hold the core in reset until start-up delays finish
// Assumes: APB slave on pclk; oscillator pins arrive asynchronously
// Notes: configuration register stands in for the fuse word
//
// How it works
// R1: core reset held until enabled delays expire
// R2: power-up timer runs only if enable_n zero
// R3: crystal modes count 1024 oscillator cycles
// R4: PLL with external osc adds 2 ms
// R5: controller-ready delay runs in parallel
// R6: EC, RC, internal modes skip oscillator count
// R7: start-immediate zero waits for stable oscillator except in external modes
// R8: start-immediate one starts clock at once
// R9: stable flag readable in oscillator control
// R10: write-enable cleared at power-up
// R11: EEPROM writes blocked during power-up timer
// R12: write needs enable plus unlock sequence
// R13: software writes 55h then AAh first
`timescale 1ns/1ps
`include "pwrup_map.vh"
module power_up_delay_sequencer #(
	parameter POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_CYC,
	parameter PLL_CYCLES = `PLL_LOCK_CYC,
	parameter OST_COUNT = `OST_CYCLES,
	parameter CSD_CYCLES = `CSD_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire osc_clk_in,
	input wire fast_osc_ready_in,
	output wire core_reset_n,
	output wire sys_clk_enable,
	output wire eeprom_write_start
);
	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	localparam [3:0] ST_HOLD = 4'b0001;
	localparam [3:0] ST_WAIT = 4'b0010;
	localparam [3:0] ST_RUN = 4'b0100;
	localparam [3:0] ST_CLK = 4'b1000;
	localparam [1:0] KEY_IDLE = 2'b01;
	localparam [1:0] KEY_HALF = 2'b10;
	localparam [1:0] KEY_OPEN = 2'b11;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [5:0] cfg_ff;
	reg eeprom_write_enable_ff;
	reg [1:0] key_ff;
	reg start_ff;
	reg [2:0] osc_sync_ff;
	reg osc_lvl_ff;
	reg [2:0] fast_sync_ff;
	reg fast_stable_ff;
	reg [31:0] rdata_ff;
	reg [31:0] nxt_rdata;
	wire power_up_timer_done;
	wire ost_done;
	wire pll_done;
	wire csd_done;
	wire osc_edge;
	wire crystal_mode;
	wire ext_mode;
	wire power_up_timer_on;
	wire pll_on;
	wire power_up_timer_running;
	wire delays_done;
	wire wr_acc;
	wire rd_acc;
	wire addr_ok;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function is_crystal;
		input [2:0] mode;
		begin
			is_crystal = (mode == `MODE_LP) || (mode == `MODE_XT) ||
				(mode == `MODE_HS);
		end
	endfunction

	function hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// A change counts only when the second and third stages agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sync_ff <= 3'h0;
			osc_lvl_ff <= 1'b0;
			fast_sync_ff <= 3'h0;
			fast_stable_ff <= 1'b0;
		end else begin
			osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_in};
			fast_sync_ff <= {fast_sync_ff[1:0], fast_osc_ready_in};
			if (osc_sync_ff[1] == osc_sync_ff[2])
				osc_lvl_ff <= osc_sync_ff[2];
			if (fast_sync_ff[1] == fast_sync_ff[2])
				fast_stable_ff <= fast_sync_ff[2];
		end
	end

	// Oscillator must run below pclk/6 for every cycle to be counted
	assign osc_edge = (osc_sync_ff[1] == osc_sync_ff[2]) &
		osc_sync_ff[2] & ~osc_lvl_ff;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;
	assign addr_ok = hit(paddr, `OFF_CONFIG) | hit(paddr, `OFF_OSC_CTRL) |
		hit(paddr, `OFF_EE_CTRL) | hit(paddr, `OFF_UNLOCK_KEY) |
		hit(paddr, `OFF_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// ----------------------------------------------------------------
	// Start-up sequencing
	// ----------------------------------------------------------------
	assign crystal_mode = is_crystal(cfg_ff[3:1]);
	assign ext_mode = crystal_mode | (cfg_ff[3:1] == `MODE_EC) |
		(cfg_ff[3:1] == `MODE_RC);
	// R2: timer enabled by zero bit
	assign power_up_timer_on = ~cfg_ff[`CFG_POWER_UP_TIMER_EN_N];
	// R4: PLL lock wait only with external osc
	assign pll_on = cfg_ff[`CFG_PLL_EN] & ext_mode;
	assign power_up_timer_running = start_ff & power_up_timer_on & ~power_up_timer_done;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_ff <= 1'b0;
		else
			start_ff <= 1'b1;
	end

	delay_counter #(.WIDTH(24), .COUNT(POWER_UP_TIMER_CYCLES[23:0])) u_power_up_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_ff & power_up_timer_on),
		.tick(1'b1),
		.done(power_up_timer_done)
	);

	// R3: count 1024 oscillator edges
	delay_counter #(.WIDTH(24), .COUNT(OST_COUNT[23:0])) u_ost (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_ff & crystal_mode),
		.tick(osc_edge),
		.done(ost_done)
	);

	// R4: begins only after the oscillator count
	delay_counter #(.WIDTH(24), .COUNT(PLL_CYCLES[23:0])) u_pll (
		.pclk(pclk),
		.presetn(presetn),
		.start(pll_on & (ost_done | ~crystal_mode) & start_ff),
		.tick(1'b1),
		.done(pll_done)
	);

	// R5: controller-ready delay starts with the others
	delay_counter #(.WIDTH(24), .COUNT(CSD_CYCLES[23:0])) u_csd (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_ff),
		.tick(1'b1),
		.done(csd_done)
	);

	// R1: every enabled delay must be done
	// R6: skipped delays count as done
	assign delays_done = csd_done & (~power_up_timer_on | power_up_timer_done) &
		(~crystal_mode | ost_done) & (~pll_on | pll_done);

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_HOLD: begin
				if (start_ff)
					nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (delays_done)
					nxt_state = ST_RUN;
			end
			ST_RUN: begin
				// R8: start immediately when bit is one
				// R7: otherwise, outside the external modes, wait for the stable flag
				if (ext_mode || cfg_ff[`CFG_FAST_START] || fast_stable_ff)
					nxt_state = ST_CLK;
			end
			ST_CLK: begin
				nxt_state = ST_CLK;
			end
			default: begin
				nxt_state = ST_HOLD;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	assign core_reset_n = (state_ff == ST_RUN) | (state_ff == ST_CLK);
	assign sys_clk_enable = (state_ff == ST_CLK);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Configuration is frozen once the sequence leaves hold
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_ff <= `CFG_RESET_VAL;
		else if (wr_acc && hit(paddr, `OFF_CONFIG) && state_ff == ST_HOLD)
			cfg_ff <= pwdata[5:0];
	end

	// R10: write-enable clears on reset
	// R13: unlock needs 55h then AAh back to back
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eeprom_write_enable_ff <= 1'b0;
			key_ff <= KEY_IDLE;
		end else begin
			if (wr_acc && hit(paddr, `OFF_EE_CTRL))
				eeprom_write_enable_ff <= pwdata[`EE_EEPROM_WRITE_ENABLE_BIT];
			if (wr_acc && hit(paddr, `OFF_UNLOCK_KEY)) begin
				if (pwdata[7:0] == `KEY_FIRST)
					key_ff <= KEY_HALF;
				else if (pwdata[7:0] == `KEY_SECOND && key_ff == KEY_HALF)
					key_ff <= KEY_OPEN;
				else
					key_ff <= KEY_IDLE;
			end else if (wr_acc) begin
				key_ff <= KEY_IDLE;
			end
		end
	end

	// R11: blocked while power-up timer runs
	// R12: needs write-enable and unlocked key
	assign eeprom_write_start = wr_acc & hit(paddr, `OFF_EE_CTRL) &
		pwdata[`EE_WR_BIT] & eeprom_write_enable_ff & (key_ff == KEY_OPEN) &
		~power_up_timer_running;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always @* begin
		nxt_rdata = rdata_ff;
		if (rd_acc) begin
			nxt_rdata = 32'h0000_0000;
			if (hit(paddr, `OFF_CONFIG))
				nxt_rdata[5:0] = cfg_ff;
			// R9: stable flag readable in any mode
			if (hit(paddr, `OFF_OSC_CTRL))
				nxt_rdata[`OSC_STABLE_BIT] = fast_stable_ff;
			if (hit(paddr, `OFF_EE_CTRL))
				nxt_rdata[`EE_EEPROM_WRITE_ENABLE_BIT] = eeprom_write_enable_ff;
			if (hit(paddr, `OFF_STATUS)) begin
				nxt_rdata[`ST_IN_RESET] = ~core_reset_n;
				nxt_rdata[`ST_POWER_UP_TIMER_RUN] = power_up_timer_running;
				nxt_rdata[`ST_OST_DONE] = ost_done;
				nxt_rdata[`ST_PLL_DONE] = pll_done;
				nxt_rdata[`ST_CSD_DONE] = csd_done;
				nxt_rdata[`ST_CLK_RUN] = sys_clk_enable;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= nxt_rdata;
	end

	assign prdata = rdata_ff;
endmodule // power_up_delay_sequencer

// *** pwrup_chk.sv ***
// Purpose: port-level checks of the power-up sequencer
// Assumes: config is written in the first access after reset
// Notes: helper state is looser than the design, so it only guards
`timescale 1ns/1ps
module pwrup_chk #(
	parameter POWER_UP_TIMER_CYCLES = 20,
	parameter PLL_CYCLES = 20,
	parameter OST_COUNT = 8,
	parameter CSD_CYCLES = 5
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire osc_clk_in,
	input wire fast_osc_ready_in,
	input wire core_reset_n,
	input wire sys_clk_enable,
	input wire eeprom_write_start
);
	logic [15:0] cnt_ff, osc_n_ff;
	logic [31:0] cfg_ff;
	logic osc_q_ff, eeprom_write_enable_ff, key1_ff, key_ff;
	wire acc = psel && penable && pwrite;
	wire [2:0] md = cfg_ff[3:1];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 16'h0000;
			osc_n_ff <= 16'h0000;
			cfg_ff <= 32'h0000_0001;
			{osc_q_ff, eeprom_write_enable_ff, key1_ff, key_ff} <= 4'h0;
		end else begin
			cnt_ff <= cnt_ff + {15'h0000, ~&cnt_ff};
			osc_q_ff <= osc_clk_in;
			if (osc_clk_in && !osc_q_ff)
				osc_n_ff <= osc_n_ff + 16'h0001;
			if (acc && paddr == 12'h000 && cnt_ff == 16'h0000)
				cfg_ff <= pwdata;
			if (acc && paddr == 12'h008)
				eeprom_write_enable_ff <= pwdata[0];
			if (acc && paddr == 12'h00C) begin
				key1_ff <= pwdata[7:0] == 8'h55;
				if (key1_ff && pwdata[7:0] == 8'hAA)
					key_ff <= 1'b1;
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_up;
		$rose(core_reset_n);
	endsequence
	sequence s_ee_ok;
		acc && paddr == 12'h008 && pwdata[1] && eeprom_write_enable_ff && key_ff;
	endsequence
	property p_csd;
		s_up |-> cnt_ff >= CSD_CYCLES;
	endproperty
	a_csd: assert property (p_csd) else $error("early release");
	property p_power_up_timer;
		s_up |-> cfg_ff[0] || cnt_ff >= POWER_UP_TIMER_CYCLES;
	endproperty
	a_power_up_timer: assert property (p_power_up_timer) else $error("timer cut");
	property p_ost;
		s_up |-> md > 3'h2 || osc_n_ff >= OST_COUNT;
	endproperty
	a_ost: assert property (p_ost) else $error("osc count cut");
	property p_pll;
		s_up |-> !cfg_ff[4] || md > 3'h4 || cnt_ff >= PLL_CYCLES;
	endproperty
	a_pll: assert property (p_pll) else $error("lock wait cut");
	property p_fast;
		cnt_ff == CSD_CYCLES + 6 && cfg_ff[0] && !cfg_ff[4] && md > 3'h2
			&& md < 3'h6 |-> core_reset_n;
	endproperty
	a_fast: assert property (p_fast) else $error("extra delay");
	property p_imm;
		s_up ##0 cfg_ff[5] |-> ##[0:2] sys_clk_enable;
	endproperty
	a_imm: assert property (p_imm) else $error("clock late");
	property p_wait;
		sys_clk_enable && md == 3'h5 && !cfg_ff[5]
			|-> $past(fast_osc_ready_in, 3);
	endproperty
	a_wait: assert property (p_wait) else $error("clock early");
	property p_ee;
		eeprom_write_start |-> s_ee_ok;
	endproperty
	a_ee: assert property (p_ee) else $error("stray write");
	property p_blk;
		eeprom_write_start |-> cfg_ff[0] || cnt_ff >= POWER_UP_TIMER_CYCLES;
	endproperty
	a_blk: assert property (p_blk) else $error("write in timer");
	property p_err;
		psel && penable |-> pslverr == !(paddr inside {12'h000, 12'h004,
			12'h008, 12'h00C, 12'h010});
	endproperty
	a_err: assert property (p_err) else $error("bad slave error");
endmodule // pwrup_chk
bind power_up_delay_sequencer pwrup_chk #(
	.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES), .PLL_CYCLES(PLL_CYCLES),
	.OST_COUNT(OST_COUNT), .CSD_CYCLES(CSD_CYCLES)
) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_clk_in(osc_clk_in),
	.fast_osc_ready_in(fast_osc_ready_in), .core_reset_n(core_reset_n),
	.sys_clk_enable(sys_clk_enable),
	.eeprom_write_start(eeprom_write_start)
);

// *** osc_src.sv ***
// Purpose: crystal and fast internal oscillator sources
// Assumes: run follows the power-on event
// Notes: 340 ns period keeps the clock under a sixth of pclk
`timescale 1ns/1ps
module osc_src (
	input wire run,
	input wire [15:0] dly,
	output logic osc,
	output logic rdy
);
	realtime t0 = 0;
	// Clock stands still while unpowered
	initial begin
		osc = 1'b0;
		forever #170 osc = run & ~osc;
	end
	always @(posedge run) t0 = $realtime;
	// Stable only after the start-up time of this power cycle
	initial begin
		rdy = 1'b0;
		forever #10 rdy = run && ($realtime - t0 >= dly);
	end
endmodule // osc_src

// *** power_up_delay_sequencer_bench.sv ***
// Purpose: random and corner tests of the power-up sequencer
// Assumes: small delay parameters 20, 20, 8, 5
// Notes: release windows are loose because oscillator phase floats
`timescale 1ns/1ps
module power_up_delay_sequencer_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rdat, c, r;
	logic es, se;
	wire [31:0] prdata;
	wire pready, pslverr, osc, rdy, core_reset_n, sys_clk_enable, ews;
	int error_cnt = 0, compares = 0, cyc = 0, tmo = 0, n, i;
	int seed = 32'h05D4;
	osc_src m (.run(presetn), .dly(16'h07D0), .osc(osc), .rdy(rdy));
	power_up_delay_sequencer #(.POWER_UP_TIMER_CYCLES(20), .PLL_CYCLES(20),
		.OST_COUNT(8), .CSD_CYCLES(5)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_clk_in(osc),
		.fast_osc_ready_in(rdy), .core_reset_n(core_reset_n),
		.sys_clk_enable(sys_clk_enable), .eeprom_write_start(ews));
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= presetn ? cyc + 1 : 0;
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			error_cnt++;
			complete_run;
		end
	end
	task complete_run;
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task cmp_rng(input int g, input int lo);
		compares++;
		if (g < lo || g > lo + 14) begin
			error_cnt++;
			$display("Error %0t: release at %0d", $time, g);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		es = ews;
		se = pslverr;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Config write straddles the release so it lands on the first edge
	task rst(input logic [31:0] cf);
		@(posedge pclk);
		{presetn, psel, pwrite, penable} <= 4'h6;
		paddr <= 12'h000;
		pwdata <= cf;
		repeat (10) @(posedge pclk);
		cmp(core_reset_n, 32'h0);
		presetn <= 1'b1;
		penable <= 1'b1;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wcore;
		while (core_reset_n !== 1'b1) @(negedge pclk);
		n = cyc;
	endtask
	task ee(input logic [31:0] d, input logic e);
		xfer(1'b1, 12'h008, d);
		cmp(es, e);
	endtask
	task ky;
		xfer(1'b1, 12'h00C, 32'h55);
		xfer(1'b1, 12'h00C, 32'hAA);
	endtask
	// Parallel delays take the longest; lock wait follows the osc count
	function int lo(input logic [31:0] cf);
		int t;
		t = (cf[3:1] < 3'h3) ? 60 : 0;
		if (cf[4] && cf[3:1] < 3'h5)
			t += 20;
		if (!cf[0] && t < 20)
			t = 20;
		return (t < 5) ? 5 : t;
	endfunction
	initial begin
		for (i = 0; i < 12; i++) begin
			r = $random(seed);
			c = {26'h0, i > 5, r[1], 3'(i % 6), r[0]};
			rst(c);
			xfer(1'b0, 12'h004, 32'h0);
			cmp(rdat, 32'h0);
			wcore;
			cmp_rng(n, lo(c));
			repeat (3) @(negedge pclk);
			cmp(sys_clk_enable, !(c[3:1] == 3'h5 && !c[5]));
			repeat (60) @(negedge pclk);
			cmp(sys_clk_enable, 32'h1);
			xfer(1'b0, 12'h004, 32'h0);
			cmp(rdat, 32'h1);
			xfer(1'b1, 12'h000, ~c);
			xfer(1'b0, 12'h000, 32'h0);
			cmp(rdat, c);
		end
		rst(32'h7);
		wcore;
		ee(32'h1, 1'b0);
		cmp(se, 1'b0);
		cmp(pready, 32'h1);
		ee(32'h3, 1'b0);
		xfer(1'b1, 12'h00C, 32'hAA);
		xfer(1'b1, 12'h00C, 32'h55);
		ee(32'h3, 1'b0);
		ky;
		ee(32'h3, 1'b1);
		xfer(1'b0, 12'h014, 32'h0);
		cmp(rdat, 32'h0);
		cmp(se, 1'b1);
		xfer(1'b0, 12'h010, 32'h0);
		cmp(rdat, 32'h30);
		rst(32'h7);
		ky;
		ee(32'h3, 1'b0);
		rst(32'h6);
		ee(32'h1, 1'b0);
		ky;
		ee(32'h3, 1'b0);
		wcore;
		ee(32'h1, 1'b0);
		ky;
		ee(32'h3, 1'b1);
		complete_run;
	end
endmodule // power_up_delay_sequencer_bench
